// *** src/vic_defines.svh ***
// Purpose: Named constants of the vectored interrupt controller
// Assumes: Included by the controller, its assertions and the test bench
// Notes:   Offsets are byte addresses on the register bus
`ifndef VIC_DEFINES_SVH
`define VIC_DEFINES_SVH

`define VIC_NUM_SLOTS      15
`define VIC_IDX_W          4
`define VIC_VEC_W          16
// Vector layout
`define VIC_RESET_VEC      16'h0000
`define VIC_VEC_BASE       16'h0003
`define VIC_VEC_SHIFT      3
// Slot classes
`define VIC_RSVD_MASK      15'h2300
`define VIC_HWCLR_MASK     15'h000F
// Register offsets
`define VIC_OFF_EN_A       8'h00
`define VIC_OFF_EN_B       8'h04
`define VIC_OFF_PRI_A      8'h08
`define VIC_OFF_PRI_B      8'h0C
`define VIC_OFF_PEND       8'h10
`define VIC_OFF_STAT       8'h14
// Reset values
`define VIC_EN_A_RST       8'h00
`define VIC_EN_B_RST       8'h00
`define VIC_PRI_A_RST      8'h00
`define VIC_PRI_B_RST      8'h00
`define VIC_PEND_RST       15'h0000
// Fields
`define VIC_GIE_BIT        7
`define VIC_PRI_A_FIXED    8'h80
// Timing
`define VIC_CALL_CYCLES    3'h4
`define VIC_CNT_ONE        3'h1
// Bus answers
`define VIC_RESP_OKAY      2'h0
`define VIC_RESP_SLVERR    2'h2

`endif

// *** src/vic_pkg.sv ***
// Purpose: Types of the vectored interrupt controller
// Assumes: Nothing
// Notes:   Constants live in vic_defines.svh
package vic_pkg;

   typedef enum logic [0:0]
   {
      VIC_IDLE = 1'b0,
      VIC_CALL = 1'b1
   } vic_state_t;

endpackage : vic_pkg

// *** src/vic_ctrl.sv ***
// Purpose: Two-level vectored interrupt controller with AXI4-Lite registers
// Assumes: CPU pulses instr_done at each instruction boundary
// Notes:   Vector call is timed here; CPU follows call_busy/call_vector
`timescale 1ns/1ps
`include "vic_defines.svh"

module vic_ctrl
(
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   // AXI4-Lite slave
   input  wire logic [7:0]                  s_axi_awaddr,
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   input  wire logic [31:0]                 s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   output logic [1:0]                       s_axi_bresp,
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   input  wire logic [7:0]                  s_axi_araddr,
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   output logic [31:0]                      s_axi_rdata,
   output logic [1:0]                       s_axi_rresp,
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   // Peripheral flag-set events, one per ordered slot
   input  wire logic [`VIC_NUM_SLOTS-1:0]   src_event,
   // CPU core
   input  wire logic                        instr_done,
   input  wire logic                        reti_done,
   output logic                             call_busy,
   output logic                             call_done,
   output logic [`VIC_VEC_W-1:0]            call_vector,
   output vic_pkg::vic_state_t              call_state,
   output logic                             active_low,
   output logic                             active_high,
   output logic [`VIC_NUM_SLOTS-1:0]        pending
);
   import vic_pkg::*;

   // -------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------
   logic [7:0]                  enable_reg_a;
   logic [7:0]                  enable_reg_b;
   logic [7:0]                  priority_select_reg_a;
   logic [7:0]                  priority_select_reg_b;
   logic                        global_irq_enable;
   logic [`VIC_NUM_SLOTS-1:0]   en_slot;
   logic [`VIC_NUM_SLOTS-1:0]   pri_slot;
   logic [`VIC_NUM_SLOTS-1:0]   eligible;
   logic [`VIC_NUM_SLOTS-1:0]   hi_req;
   logic [`VIC_NUM_SLOTS-1:0]   lo_req;
   logic                        next_sel_valid;
   logic                        next_sel_high;
   logic [`VIC_IDX_W-1:0]       next_sel_idx;
   logic                        sel_valid;
   logic                        sel_high;
   logic [`VIC_IDX_W-1:0]       sel_idx;
   logic                        take_call;
   logic [2:0]                  call_cnt;
   logic [`VIC_NUM_SLOTS-1:0]   hw_clear;
   // Bus
   logic                        aw_held;
   logic                        w_held;
   logic [7:0]                  aw_addr;
   logic [31:0]                 w_data;
   logic [3:0]                  w_strb;
   logic                        do_write;
   logic                        pend_write;
   logic                        wr_hit;
   logic [31:0]                 rd_word;
   logic                        rd_hit;

   assign global_irq_enable = enable_reg_a[`VIC_GIE_BIT];

   // -------------------------------------------------------------------
   // Slot mapping
   // -------------------------------------------------------------------
   // Reserved slots 8, 9 and 13 carry constant zero
   assign en_slot  = {enable_reg_b[7], 1'b0, enable_reg_b[5:3], 2'b00,
                      enable_reg_b[0], enable_reg_a[6:0]};
   assign pri_slot = {priority_select_reg_b[7], 1'b0,
                      priority_select_reg_b[5:3], 2'b00,
                      priority_select_reg_b[0],
                      priority_select_reg_a[6:0]};

   // -------------------------------------------------------------------
   // Request filter and priority decode
   // -------------------------------------------------------------------
   // Disabled or globally masked flags stay pending but are not seen
   assign eligible = pending & en_slot & ~`VIC_RSVD_MASK
                     & {`VIC_NUM_SLOTS{global_irq_enable}};

   always_comb
   begin
      hi_req = eligible & pri_slot;
      lo_req = eligible & ~pri_slot;
      if (active_high)
      begin
         hi_req = '0;
         lo_req = '0;
      end
      else if (active_low)
      begin
         lo_req = '0;
      end
   end

   always_comb
   begin
      next_sel_valid = 1'b0;
      next_sel_high  = 1'b0;
      next_sel_idx   = '0;
      // Descending scan so the lowest index is the last to win
      for (int i = `VIC_NUM_SLOTS - 1; i >= 0; i--)
      begin
         if (lo_req[i])
         begin
            next_sel_valid = 1'b1;
            next_sel_idx   = `VIC_IDX_W'(i);
         end
      end
      for (int i = `VIC_NUM_SLOTS - 1; i >= 0; i--)
      begin
         if (hi_req[i])
         begin
            next_sel_valid = 1'b1;
            next_sel_high  = 1'b1;
            next_sel_idx   = `VIC_IDX_W'(i);
         end
      end
   end

   // Decode snapshot for the status word only
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sel_valid <= 1'b0;
         sel_high  <= 1'b0;
         sel_idx   <= '0;
      end
      else
      begin
         sel_valid <= next_sel_valid & ~take_call;
         sel_high  <= next_sel_high;
         sel_idx   <= next_sel_idx;
      end
   end

   // -------------------------------------------------------------------
   // Call start
   // -------------------------------------------------------------------
   // This cycle's decode is the detect cycle; a second stage would
   // stretch the response. Never at the return itself, so the first
   // boundary after a return ends the one instruction run before it.
   assign take_call = (call_state == VIC_IDLE) && next_sel_valid
                      && instr_done && !reti_done;

   // -------------------------------------------------------------------
   // Vector call sequencer
   // -------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         call_state  <= VIC_IDLE;
         call_cnt    <= '0;
         call_vector <= `VIC_RESET_VEC;
      end
      else
      begin
         case (call_state)
            VIC_IDLE:
            begin
               if (take_call)
               begin
                  call_state  <= VIC_CALL;
                  call_cnt    <= `VIC_CNT_ONE;
                  call_vector <= `VIC_VEC_BASE
                     + {`VIC_VEC_W'(next_sel_idx) << `VIC_VEC_SHIFT};
               end
            end
            VIC_CALL:
            begin
               if (call_cnt == `VIC_CALL_CYCLES)
               begin
                  call_state <= VIC_IDLE;
               end
               else
               begin
                  call_cnt <= call_cnt + `VIC_CNT_ONE;
               end
            end
            default:
            begin
               call_state <= VIC_IDLE;
            end
         endcase
      end
   end

   assign call_busy = (call_state == VIC_CALL);
   assign call_done = call_busy && (call_cnt == `VIC_CALL_CYCLES);

   // -------------------------------------------------------------------
   // In-service levels
   // -------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         active_low  <= 1'b0;
         active_high <= 1'b0;
      end
      else if (take_call)
      begin
         if (next_sel_high)
         begin
            active_high <= 1'b1;
         end
         else
         begin
            active_low <= 1'b1;
         end
      end
      else if (reti_done)
      begin
         // Return ends the innermost routine, high nests over low
         if (active_high)
         begin
            active_high <= 1'b0;
         end
         else
         begin
            active_low <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------
   // Pending flags
   // -------------------------------------------------------------------
   always_comb
   begin
      hw_clear = '0;
      if (take_call)
      begin
         hw_clear[next_sel_idx] = 1'b1;
      end
      hw_clear = hw_clear & `VIC_HWCLR_MASK;
   end

   // Events win over a software or hardware clear in the same cycle
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pending <= `VIC_PEND_RST;
      end
      else if (pend_write)
      begin
         // Vectoring clear still applies under a software write
         pending <= (w_data[`VIC_NUM_SLOTS-1:0] & ~`VIC_RSVD_MASK
                     & ~hw_clear)
                    | (src_event & ~`VIC_RSVD_MASK);
      end
      else
      begin
         pending <= (pending & ~hw_clear)
                    | (src_event & ~`VIC_RSVD_MASK);
      end
   end

   // -------------------------------------------------------------------
   // AXI4-Lite write channel
   // -------------------------------------------------------------------
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign do_write      = aw_held && w_held && !s_axi_bvalid;
   assign wr_hit        = (aw_addr == `VIC_OFF_EN_A)
                          || (aw_addr == `VIC_OFF_EN_B)
                          || (aw_addr == `VIC_OFF_PRI_A)
                          || (aw_addr == `VIC_OFF_PRI_B)
                          || (aw_addr == `VIC_OFF_PEND);
   assign pend_write    = do_write && (aw_addr == `VIC_OFF_PEND)
                          && (&w_strb[1:0]);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= '0;
         w_data       <= '0;
         w_strb       <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `VIC_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `VIC_RESP_OKAY : `VIC_RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Control registers, byte lane 0 only
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         enable_reg_a          <= `VIC_EN_A_RST;
         enable_reg_b          <= `VIC_EN_B_RST;
         priority_select_reg_a <= `VIC_PRI_A_RST;
         priority_select_reg_b <= `VIC_PRI_B_RST;
      end
      else if (do_write && w_strb[0])
      begin
         case (aw_addr)
            `VIC_OFF_EN_A:  enable_reg_a          <= w_data[7:0];
            `VIC_OFF_EN_B:  enable_reg_b          <= w_data[7:0];
            `VIC_OFF_PRI_A: priority_select_reg_a <= w_data[7:0];
            `VIC_OFF_PRI_B: priority_select_reg_b <= w_data[7:0];
            default:        enable_reg_a          <= enable_reg_a;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // AXI4-Lite read channel
   // -------------------------------------------------------------------
   always_comb
   begin
      rd_word = '0;
      rd_hit  = 1'b1;
      case (s_axi_araddr)
         `VIC_OFF_EN_A:  rd_word[7:0] = enable_reg_a;
         `VIC_OFF_EN_B:  rd_word[7:0] = enable_reg_b;
         // Top bit of the first priority register reads as one
         `VIC_OFF_PRI_A: rd_word[7:0] = priority_select_reg_a
                                        | `VIC_PRI_A_FIXED;
         `VIC_OFF_PRI_B: rd_word[7:0] = priority_select_reg_b;
         `VIC_OFF_PEND:  rd_word[`VIC_NUM_SLOTS-1:0] = pending;
         `VIC_OFF_STAT:  rd_word = {call_vector, 8'h00, sel_idx,
                                    sel_valid, call_busy,
                                    active_high, active_low};
         default:        rd_hit = 1'b0;
      endcase
   end

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= `VIC_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= rd_hit ? `VIC_RESP_OKAY : `VIC_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule : vic_ctrl

// *** bench/vic_ctrl_sva.sv ***
// Purpose: Port-level assertions for the vectored interrupt controller
// Assumes: Single clock domain, reset active low
// Notes:   Bound to every vic_ctrl instance
`timescale 1ns/1ps
`include "vic_defines.svh"

module vic_ctrl_sva
(
   input wire logic                      clk,
   input wire logic                      rst_n,
   input wire logic                      instr_done,
   input wire logic                      reti_done,
   input wire logic                      call_busy,
   input wire logic                      call_done,
   input wire logic [`VIC_VEC_W-1:0]     call_vector,
   input wire logic                      active_low,
   input wire logic                      active_high,
   input wire logic [`VIC_NUM_SLOTS-1:0] src_event,
   input wire logic [`VIC_NUM_SLOTS-1:0] pending
);
   logic [14:0] sel;

   // -------------------------------------------------
   // Call sequences
   // -------------------------------------------------
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   assign sel = 15'h0001 << call_vector[6:3];

   sequence s_start;
      $rose(call_busy);
   endsequence
   sequence s_run;
      call_busy[*4] ##1 !call_busy;
   endsequence
   sequence s_done;
      !call_done[*3] ##1 call_done;
   endsequence

   a_call_length: assert property (s_start |-> s_run)
      else $error("call not four cycles long");
   a_done_fourth: assert property (s_start |-> s_done)
      else $error("call done not in fourth cycle");
   a_start_cause: assert property (
      s_start |-> $past(instr_done) && !$past(reti_done))
      else $error("call started off an instruction boundary");
   a_vector_slot: assert property (
      s_start |-> call_vector[2:0] == 3'h3 && call_vector <= 16'h0073
                  && (sel & `VIC_RSVD_MASK) == 15'h0000)
      else $error("call vector not a usable slot");
   a_high_blocks: assert property (s_start |-> !$past(active_high))
      else $error("high routine was preempted");
   a_low_preempt: assert property (
      (s_start and ($past(active_low))) |-> active_high)
      else $error("low routine preempted by low request");
   a_hw_clear: assert property (
      (s_start and ((sel & `VIC_HWCLR_MASK) != 15'h0000)
               and (($past(src_event) & sel) == 15'h0000))
      |-> (pending & sel) == 15'h0000)
      else $error("pin or legacy timer flag not cleared");
   a_sw_keep: assert property (
      (s_start and ((sel & ~`VIC_HWCLR_MASK) != 15'h0000))
      |-> (pending & sel) != 15'h0000)
      else $error("software-cleared flag lost on call");
   a_rsvd_idle: assert property ((pending & `VIC_RSVD_MASK) == 15'h0000)
      else $error("reserved slot pending");
   a_reset_vec: assert property ($rose(rst_n) |-> call_vector == `VIC_RESET_VEC)
      else $error("call vector not reset vector");
endmodule : vic_ctrl_sva

bind vic_ctrl vic_ctrl_sva u_sva
(
   .clk, .rst_n, .instr_done, .reti_done, .call_busy, .call_done,
   .call_vector, .active_low, .active_high, .src_event, .pending
);

// *** bench/vic_cpu_model.sv ***
// Purpose: CPU core model giving instruction boundaries and returns
// Assumes: gap is one or more clocks per instruction
// Notes:   Boundaries pause while the vector call runs
`timescale 1ns/1ps

module vic_cpu_model
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       call_busy,
   input  wire logic [3:0] gap,
   input  wire logic       ret_req,
   output logic            instr_done,
   output logic            reti_done
);
   logic [3:0] cnt;
   logic       in_ret;

   // -------------------------------------------------
   // Instruction stream
   // -------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt        <= 4'h0;
         in_ret     <= 1'b0;
         instr_done <= 1'b0;
         reti_done  <= 1'b0;
      end
      else
      begin
         instr_done <= 1'b0;
         reti_done  <= 1'b0;
         if (ret_req)
         begin
            in_ret <= 1'b1;
            cnt    <= 4'h0;
         end
         else if (!call_busy)
         begin
            cnt <= cnt + 4'h1;
            // Return always costs five clocks
            if (cnt + 4'h1 >= (in_ret ? 4'h5 : gap))
            begin
               cnt        <= 4'h0;
               in_ret     <= 1'b0;
               instr_done <= !in_ret;
               reti_done  <= in_ret;
            end
         end
      end
   end
endmodule : vic_cpu_model

// *** bench/two_level_vectored_irq_ctrl_test.sv ***
// Purpose: Self-checking bench of the vectored interrupt controller
// Assumes: CPU model gives instruction boundaries and returns
// Notes:   Single-source vectoring runs from a table of rows
`timescale 1ns/1ps
`include "vic_defines.svh"

module two_level_vectored_irq_ctrl_test;
   import vic_pkg::*;

   typedef struct packed {
      logic [3:0]  idx;
      logic [7:0]  ea;
      logic [7:0]  eb;
      logic [15:0] vec;
      logic        clr;
   } vic_row_t;

   vic_row_t    rows [12] = '{
      '{4'h0, 8'h01, 8'h00, 16'h0003, 1'b1},
      '{4'h1, 8'h02, 8'h00, 16'h000B, 1'b1},
      '{4'h2, 8'h04, 8'h00, 16'h0013, 1'b1},
      '{4'h3, 8'h08, 8'h00, 16'h001B, 1'b1},
      '{4'h4, 8'h10, 8'h00, 16'h0023, 1'b0},
      '{4'h5, 8'h20, 8'h00, 16'h002B, 1'b0},
      '{4'h6, 8'h40, 8'h00, 16'h0033, 1'b0},
      '{4'h7, 8'h00, 8'h01, 16'h003B, 1'b0},
      '{4'hA, 8'h00, 8'h08, 16'h0053, 1'b0},
      '{4'hB, 8'h00, 8'h10, 16'h005B, 1'b0},
      '{4'hC, 8'h00, 8'h20, 16'h0063, 1'b0},
      '{4'hE, 8'h00, 8'h80, 16'h0073, 1'b0}};
   logic        clk = 1'b0, rst_n = 1'b0, ret_req = 1'b0, bq = 1'b0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb = 4'hF, gap = 4'h1;
   logic [14:0] src_event = 15'h0000, pending;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, instr_done, reti_done, call_busy, call_done;
   logic        active_low, active_high;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [15:0] call_vector;
   vic_state_t  call_state;
   int          miscompares = 0, cmp_count = 0, calls = 0, ninst = 0;
   int          ninst_at = 0, n, c0;

   vic_ctrl u_dut
   (
      .clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .src_event, .instr_done,
      .reti_done, .call_busy, .call_done, .call_vector, .call_state,
      .active_low, .active_high, .pending
   );

   vic_cpu_model u_cpu
   (
      .clk, .rst_n, .call_busy, .gap, .ret_req, .instr_done, .reti_done
   );

   always #10 clk = ~clk;

   // -------------------------------------------------
   // Call and boundary monitor
   // -------------------------------------------------
   always @(posedge clk)
   begin
      bq <= call_busy;
      if (call_busy && !bq)
      begin
         calls    <= calls + 1;
         ninst_at <= ninst;
      end
      if (reti_done)
         ninst <= 0;
      else if (instr_done)
         ninst <= ninst + 1;
   end

   // -------------------------------------------------
   // Tasks
   // -------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic pa, pw, ta, tw;
      pa = 1'b1;
      pw = 1'b1;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      while (pa || pw)
      begin
         @(negedge clk);
         ta = s_axi_awready;
         tw = s_axi_wready;
         @(posedge clk);
         pa = pa && !ta;
         pw = pw && !tw;
         s_axi_awvalid <= pa;
         s_axi_wvalid  <= pw;
      end
      do
      begin
         @(negedge clk);
         ta = s_axi_bvalid;
         r  = s_axi_bresp;
         @(posedge clk);
      end
      while (!ta);
   endtask : wr

   task automatic rd(input logic [7:0] a);
      logic t;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      do
      begin
         @(negedge clk);
         t = s_axi_arready;
         @(posedge clk);
      end
      while (!t);
      s_axi_arvalid <= 1'b0;
      do
      begin
         @(negedge clk);
         t = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge clk);
      end
      while (!t);
   endtask : rd

   // Waits for the fourth call cycle, then checks the vector
   task automatic serve(input logic [15:0] v);
      for (n = 0; n < 60; n++)
      begin
         @(negedge clk);
         if (call_done === 1'b1)
            break;
      end
      chk("call_done", 32'h1, {31'h0, call_done});
      chk("call_state", 32'(VIC_CALL), 32'(call_state));
      chk("call_vector", {16'h0, v}, {16'h0, call_vector});
      @(posedge clk);
   endtask : serve

   task automatic pulse_ret();
      ret_req <= 1'b1;
      @(posedge clk);
      ret_req <= 1'b0;
   endtask : pulse_ret

   task automatic hold(input int k);
      c0 = calls;
      repeat (k) @(posedge clk);
      chk("calls", 32'(c0), 32'(calls));
   endtask : hold

   task automatic print_verdict();
      $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : print_verdict

   // -------------------------------------------------
   // Sequence
   // -------------------------------------------------
   initial
   begin
      #400000;
      miscompares++;
      print_verdict();
   end

   initial
   begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      foreach (rows[i])
      begin
         wr(`VIC_OFF_EN_A, {24'h0, rows[i].ea | 8'h80});
         wr(`VIC_OFF_EN_B, {24'h0, rows[i].eb});
         src_event <= 15'h0001 << rows[i].idx;
         @(posedge clk);
         src_event <= 15'h0000;
         serve(rows[i].vec);
         chk("latency", 32'd4, 32'(n));
         chk("pend_bit", 32'(!rows[i].clr), 32'(pending[rows[i].idx]));
         wr(`VIC_OFF_PEND, 32'h0);
         pulse_ret();
         repeat (10) @(posedge clk);
      end
      // Second reset in mid-run, then register defaults
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk("rst_vector", 32'h0, {16'h0, call_vector});
      rd(`VIC_OFF_PRI_A);
      chk("pri_a", 32'h80, d);
      rd(`VIC_OFF_PRI_B);
      chk("pri_b", 32'h0, d);
      rd(`VIC_OFF_EN_A);
      chk("en_a", 32'h0, d);
      rd(8'h18);
      chk("unmapped", {30'h0, `VIC_RESP_SLVERR}, {30'h0, r});
      wr(8'h18, 32'h0);
      chk("bresp", {30'h0, `VIC_RESP_SLVERR}, {30'h0, r});
      gap <= 4'h3;
      wr(`VIC_OFF_PEND, 32'h7FFF);
      rd(`VIC_OFF_PEND);
      chk("pend", 32'h5CFF, d);
      wr(`VIC_OFF_PRI_A, 32'h40);
      wr(`VIC_OFF_PRI_B, 32'h20);
      wr(`VIC_OFF_EN_B, 32'hB9);
      wr(`VIC_OFF_EN_A, 32'h7F);
      hold(12);
      wr(`VIC_OFF_EN_A, 32'hFF);
      serve(16'h0033);
      hold(20);
      wr(`VIC_OFF_PEND, 32'h5CBF);
      pulse_ret();
      serve(16'h0063);
      chk("instr_after_ret", 32'd1, 32'(ninst_at));
      wr(`VIC_OFF_PEND, 32'h4CBF);
      pulse_ret();
      serve(16'h0003);
      chk("pend0", 32'h0, 32'(pending[0]));
      hold(15);
      src_event <= 15'h1000;
      @(posedge clk);
      src_event <= 15'h0000;
      serve(16'h0063);
      chk("nest", 32'h3, {30'h0, active_high, active_low});
      print_verdict();
   end
endmodule : two_level_vectored_irq_ctrl_test
